// ==== odid_defs.vh ====
`ifndef ODID_DEFS_VH
`define ODID_DEFS_VH

// register byte offsets
`define ODID_OFS_CH0        8'h00
`define ODID_OFS_CH4        8'h04
`define ODID_OFS_CH8        8'h08
`define ODID_OFS_INT_STAT   8'h0C
`define ODID_OFS_INT_MASK   8'h10
`define ODID_OFS_PIN_STAT   8'h14

// control/status register fields
`define ODID_MODE_LSB       0
`define ODID_MODE_MSB       3
`define ODID_COUNT_LSB      4
`define ODID_COUNT_MSB      7
`define ODID_ENABLE_BIT     8
`define ODID_FLAG_BIT       12

// pin status register fields
`define ODID_PINS_LSB       0
`define ODID_PINS_MSB       2
`define ODID_DISABLE_BIT    4

// reset values
`define ODID_CTRL_RESET     4'h0
`define ODID_MASK_RESET     3'h0

// detection modes
`define ODID_MODE_EDGE      4'h0
`define ODID_MODE_DIV8      4'h1
`define ODID_MODE_DIV16     4'h2
`define ODID_MODE_DIV128    4'h3
`define ODID_MODE_DIV1      4'h4
`define ODID_MODE_DIV2      4'h5
`define ODID_MODE_DIV4      4'h6

// prescaler masks, tick when all masked bits are one
`define ODID_MASK_DIV1      7'h00
`define ODID_MASK_DIV2      7'h01
`define ODID_MASK_DIV4      7'h03
`define ODID_MASK_DIV8      7'h07
`define ODID_MASK_DIV16     7'h0F
`define ODID_MASK_DIV128    7'h7F

// sample count field zero stands for this many samples
`define ODID_COUNT_ZERO     5'h10

// bus responses
`define ODID_RESP_OKAY      2'h0
`define ODID_RESP_SLVERR    2'h2

`endif

// ==== odid_sync.v ====
`timescale 1ns/100ps
`include "odid_defs.vh"

module odid_sync (
	input  wire       i_ref_clk,
	input  wire       i_srst,
	input  wire [2:0] i_async,
	output wire [2:0] o_sync
);

	reg [2:0] meta;
	reg [2:0] stable;

	// pins idle high, so reset to high to avoid a false falling edge
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			meta   <= 3'h7;
			stable <= 3'h7;
		end else begin
			meta   <= i_async;
			stable <= meta;
		end
	end

	assign o_sync = stable;

endmodule

// ==== odid_chan.v ====
`timescale 1ns/100ps
`include "odid_defs.vh"

module odid_chan (
	input  wire       i_ref_clk,
	input  wire       i_srst,
	input  wire       i_pin,
	input  wire [3:0] i_mode,
	input  wire [3:0] i_count,
	input  wire       i_clear,
	output reg        o_flag,
	output wire       o_set
);

	reg  [6:0] div_cnt;
	reg  [4:0] low_cnt;
	reg        prev_pin;
	wire [6:0] mask;
	wire       tick;
	wire       sampling;
	wire [4:0] needed;
	wire       edge_hit;
	wire       samp_hit;

	function [6:0] div_mask;
		input [3:0] mode;
		begin
			case (mode)
				`ODID_MODE_DIV8:   div_mask = `ODID_MASK_DIV8;
				`ODID_MODE_DIV16:  div_mask = `ODID_MASK_DIV16;
				`ODID_MODE_DIV128: div_mask = `ODID_MASK_DIV128;
				`ODID_MODE_DIV2:   div_mask = `ODID_MASK_DIV2;
				`ODID_MODE_DIV4:   div_mask = `ODID_MASK_DIV4;
				default:           div_mask = `ODID_MASK_DIV1;
			endcase
		end
	endfunction

	assign mask     = div_mask(i_mode);
	assign tick     = ((div_cnt & mask) == mask);
	// prohibited codes match neither detector and never set the flag
	assign sampling = (i_mode >= `ODID_MODE_DIV8) && (i_mode <= `ODID_MODE_DIV4);
	assign needed   = (i_count == 4'h0) ? `ODID_COUNT_ZERO : {1'b0, i_count};
	assign edge_hit = (i_mode == `ODID_MODE_EDGE) && prev_pin && !i_pin;
	assign samp_hit = sampling && tick && !i_pin && ((low_cnt + 5'h01) == needed);
	assign o_set    = edge_hit || samp_hit;

	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			div_cnt  <= 7'h00;
			low_cnt  <= 5'h00;
			prev_pin <= 1'b1;
			o_flag   <= 1'b0;
		end else begin
			div_cnt  <= div_cnt + 7'h01;
			prev_pin <= i_pin;
			if (!sampling) begin
				low_cnt <= 5'h00;
			end else if (tick) begin
				if (i_pin) begin
					low_cnt <= 5'h00;
				end else if (low_cnt != needed) begin
					low_cnt <= low_cnt + 5'h01;
				end
			end
			// a detection in the clearing cycle wins
			if (o_set) begin
				o_flag <= 1'b1;
			end else if (i_clear) begin
				o_flag <= 1'b0;
			end
		end
	end

endmodule

// ==== odid_top.v ====
// Function
// - Each channel's control register holds a 4-bit detection mode in bits 3 to 0.
// - Mode 0000 takes a request on a falling edge of the channel's active-low pin.
// - Modes 0001, 0010, 0011 sample the pin at clock/8, /16, /128 and take a run of lows.
// - Modes 0100, 0101, 0110 sample the pin at clock/1, /2, /4 and take a run of lows.
// - A separate 4-bit sample count sets how many consecutive lows are needed.
// - The request flag sets when the selected input condition occurs on the pin.
// - A flag clears only by reset or by writing 0 after software has read it as 1.
// - In a sampling mode the clearing write works only while the pin is high.
// - Channel 4 is an identical, independent copy with its own fields and flag.
// - Channel 8 is a third channel with the same mode encoding.
// - A set flag on an enabled channel drives the output-disable request.
// - Flag set events can raise an interrupt.
`timescale 1ns/100ps
`include "odid_defs.vh"

module odid_top (
	input  wire        i_ref_clk,
	input  wire        i_srst,
	input  wire        i_ch0_request_pin_n,
	input  wire        i_ch4_request_pin_n,
	input  wire        i_ch8_request_pin_n,
	input  wire [7:0]  i_awaddr,
	input  wire        i_awvalid,
	output reg         o_awready,
	input  wire [31:0] i_wdata,
	input  wire [3:0]  i_wstrb,
	input  wire        i_wvalid,
	output reg         o_wready,
	output reg  [1:0]  o_bresp,
	output reg         o_bvalid,
	input  wire        i_bready,
	input  wire [7:0]  i_araddr,
	input  wire        i_arvalid,
	output reg         o_arready,
	output reg  [31:0] o_rdata,
	output reg  [1:0]  o_rresp,
	output reg         o_rvalid,
	input  wire        i_rready,
	output reg         o_output_disable,
	output reg         o_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and channel detectors

	wire [2:0]  pin_sync;
	wire [2:0]  flag;
	wire [2:0]  set_evt;
	reg  [2:0]  clear_req;
	reg  [3:0]  detect_mode [0:2];
	reg  [3:0]  sample_count [0:2];
	reg  [2:0]  enable;
	reg  [2:0]  armed;
	reg  [2:0]  int_status;
	reg  [2:0]  int_mask;
	reg  [7:0]  aw_addr;
	reg         aw_have;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         w_have;
	wire        do_write;
	wire        aw_take;
	wire        w_take;
	wire        ar_take;
	integer     k;
	integer     j;

	odid_sync u_sync (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_async   ({i_ch8_request_pin_n, i_ch4_request_pin_n, i_ch0_request_pin_n}),
		.o_sync    (pin_sync)
	);

	odid_chan u_ch0 (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_pin     (pin_sync[0]),
		.i_mode    (detect_mode[0]),
		.i_count   (sample_count[0]),
		.i_clear   (clear_req[0]),
		.o_flag    (flag[0]),
		.o_set     (set_evt[0])
	);

	// second channel, fully independent state
	odid_chan u_ch4 (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_pin     (pin_sync[1]),
		.i_mode    (detect_mode[1]),
		.i_count   (sample_count[1]),
		.i_clear   (clear_req[1]),
		.o_flag    (flag[1]),
		.o_set     (set_evt[1])
	);

	odid_chan u_ch8 (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_pin     (pin_sync[2]),
		.i_mode    (detect_mode[2]),
		.i_count   (sample_count[2]),
		.i_clear   (clear_req[2]),
		.o_flag    (flag[2]),
		.o_set     (set_evt[2])
	);

	////////////////////////////////////////////////////////////////////////////////
	// address decode helpers

	// returns channel index 0..2, or 3 for a non-channel address
	function [1:0] chan_index;
		input [7:0] addr;
		begin
			if (addr == `ODID_OFS_CH0) begin
				chan_index = 2'h0;
			end else if (addr == `ODID_OFS_CH4) begin
				chan_index = 2'h1;
			end else if (addr == `ODID_OFS_CH8) begin
				chan_index = 2'h2;
			end else begin
				chan_index = 2'h3;
			end
		end
	endfunction

	function is_sampling;
		input [3:0] mode;
		begin
			is_sampling = (mode >= `ODID_MODE_DIV8) && (mode <= `ODID_MODE_DIV4);
		end
	endfunction

	function mapped;
		input [7:0] addr;
		begin
			mapped = (chan_index(addr) != 2'h3)
				|| (addr == `ODID_OFS_INT_STAT)
				|| (addr == `ODID_OFS_INT_MASK)
				|| (addr == `ODID_OFS_PIN_STAT);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order

	assign aw_take  = i_awvalid && o_awready;
	assign w_take   = i_wvalid && o_wready;
	assign ar_take  = i_arvalid && o_arready;
	assign do_write = aw_have && w_have && !o_bvalid;

	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			aw_have   <= 1'b0;
			w_have    <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h0000_0000;
			w_strb    <= 4'h0;
			o_bvalid  <= 1'b0;
			o_bresp   <= `ODID_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr   <= i_awaddr;
				aw_have   <= 1'b1;
				o_awready <= 1'b0;
			end
			if (w_take) begin
				w_data   <= i_wdata;
				w_strb   <= i_wstrb;
				w_have   <= 1'b1;
				o_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have  <= 1'b0;
				w_have   <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= mapped(aw_addr) ? `ODID_RESP_OKAY : `ODID_RESP_SLVERR;
			end
			// readiness returns only after the response is accepted
			if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// clear qualification: read as one first, then write zero

	always @* begin
		clear_req = 3'h0;
		if (do_write && (chan_index(aw_addr) != 2'h3) && w_strb[1]) begin
			for (j = 0; j < 3; j = j + 1) begin
				if ((chan_index(aw_addr) == j[1:0]) && armed[j]
					&& !w_data[`ODID_FLAG_BIT]) begin
					clear_req[j] = !is_sampling(detect_mode[j]) || pin_sync[j];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register file

	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			for (k = 0; k < 3; k = k + 1) begin
				detect_mode[k]  <= `ODID_CTRL_RESET;
				sample_count[k] <= `ODID_CTRL_RESET;
			end
			enable     <= 3'h0;
			armed      <= 3'h0;
			int_status <= 3'h0;
			int_mask   <= `ODID_MASK_RESET;
		end else begin
			for (k = 0; k < 3; k = k + 1) begin
				if (do_write && (chan_index(aw_addr) == k[1:0])) begin
					if (w_strb[0]) begin
						detect_mode[k]  <= w_data[`ODID_MODE_MSB:`ODID_MODE_LSB];
						sample_count[k] <= w_data[`ODID_COUNT_MSB:`ODID_COUNT_LSB];
					end
					if (w_strb[1]) begin
						enable[k] <= w_data[`ODID_ENABLE_BIT];
					end
					// any write to the register consumes the read
					armed[k] <= 1'b0;
				end else if (ar_take && (chan_index(i_araddr) == k[1:0]) && flag[k]) begin
					armed[k] <= 1'b1;
				end
				// set beats write-one-to-clear in the same cycle
				if (set_evt[k]) begin
					int_status[k] <= 1'b1;
				end else if (do_write && (aw_addr == `ODID_OFS_INT_STAT)
					&& w_strb[0] && w_data[k]) begin
					int_status[k] <= 1'b0;
				end
			end
			if (do_write && (aw_addr == `ODID_OFS_INT_MASK) && w_strb[0]) begin
				int_mask <= w_data[2:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read channel

	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= `ODID_RESP_OKAY;
		end else begin
			if (ar_take) begin
				o_arready <= 1'b0;
				o_rvalid  <= 1'b1;
				o_rresp   <= `ODID_RESP_OKAY;
				o_rdata   <= 32'h0000_0000;
				if (chan_index(i_araddr) != 2'h3) begin
					o_rdata[`ODID_MODE_MSB:`ODID_MODE_LSB] <= detect_mode[chan_index(i_araddr)];
					o_rdata[`ODID_COUNT_MSB:`ODID_COUNT_LSB] <=
						sample_count[chan_index(i_araddr)];
					o_rdata[`ODID_ENABLE_BIT] <= enable[chan_index(i_araddr)];
					o_rdata[`ODID_FLAG_BIT]   <= flag[chan_index(i_araddr)];
				end else if (i_araddr == `ODID_OFS_INT_STAT) begin
					o_rdata[2:0] <= int_status;
				end else if (i_araddr == `ODID_OFS_INT_MASK) begin
					o_rdata[2:0] <= int_mask;
				end else if (i_araddr == `ODID_OFS_PIN_STAT) begin
					o_rdata[`ODID_PINS_MSB:`ODID_PINS_LSB] <= pin_sync;
					o_rdata[`ODID_DISABLE_BIT] <= o_output_disable;
				end else begin
					o_rresp <= `ODID_RESP_SLVERR;
				end
			end
			if (o_rvalid && i_rready) begin
				o_rvalid  <= 1'b0;
				o_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	// registered for clean outputs; costs one cycle of disable latency
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_output_disable <= 1'b0;
			o_irq            <= 1'b0;
		end else begin
			o_output_disable <= |(flag & enable);
			o_irq            <= |(int_status & int_mask);
		end
	end

endmodule

// ==== odid_top_assertions.sv ====
`timescale 1ns/100ps

module odid_checker (
	input  wire        i_ref_clk,
	input  wire        i_srst,
	input  wire        i_awvalid,
	input  wire        o_awready,
	input  wire        i_wvalid,
	input  wire        o_wready,
	input  wire [1:0]  o_bresp,
	input  wire        o_bvalid,
	input  wire        i_bready,
	input  wire        i_arvalid,
	input  wire        o_arready,
	input  wire [31:0] o_rdata,
	input  wire        o_rvalid,
	input  wire        i_rready,
	input  wire        o_output_disable,
	input  wire        o_irq
);

default clocking @(posedge i_ref_clk); endclocking
default disable iff (i_srst);

////////////////////////////////////////////////////////////////////////////////
sequence s_rd_take;
	i_arvalid && o_arready;
endsequence

sequence s_wr_take;
	i_awvalid && o_awready && i_wvalid && o_wready;
endsequence

////////////////////////////////////////////////////////////////////////////////
reset_state_a: assert property (disable iff (1'b0) i_srst |=> !o_bvalid && !o_rvalid && !o_irq
	&& !o_output_disable && o_awready && o_arready)
	else $error("reset state wrong");
rd_answer_a: assert property (s_rd_take |=> o_rvalid)
	else $error("read answer late");
wr_answer_a: assert property (s_wr_take |-> ##2 o_bvalid)
	else $error("write answer late");
rd_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
	else $error("read data not held");
wr_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
	else $error("write response not held");
rd_done_a: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
	else $error("read not closed");
wr_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
	else $error("second write taken");
od_clear_a: assert property ($fell(o_output_disable)
	|-> o_bvalid || $past(o_bvalid) || $past(i_srst))
	else $error("disable dropped without a write");
irq_clear_a: assert property ($fell(o_irq) |-> o_bvalid || $past(o_bvalid) || $past(i_srst))
	else $error("interrupt dropped without a write");

endmodule

bind odid_top odid_checker u_odid_checker (.i_ref_clk, .i_srst, .i_awvalid, .o_awready,
	.i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata,
	.o_rvalid, .i_rready, .o_output_disable, .o_irq);

// ==== odid_src.sv ====
`timescale 1ns/100ps

module odid_src #(
	parameter DLY = 7
) (
	input  wire [2:0] i_low,
	output reg  [2:0] o_pin_n
);

// lines have pull-ups, so a released source reads high; delay keeps edges off the clock grid
initial o_pin_n = 3'h7;
always @(i_low) o_pin_n <= #DLY ~i_low;
endmodule

// ==== odid_top_tb.sv ====
`timescale 1ns/100ps
`include "odid_defs.vh"

module odid_top_tb;

typedef struct {logic [1:0] ch; logic [3:0] mode; logic [3:0] cnt; int lo; int burst; logic exp;}
	odid_row_t;

logic        i_ref_clk = 0;
logic        i_srst    = 1;
logic [7:0]  i_awaddr  = 0;
logic [7:0]  i_araddr  = 0;
logic [31:0] i_wdata   = 0;
logic [3:0]  i_wstrb   = 0;
logic        i_awvalid = 0;
logic        i_wvalid  = 0;
logic        i_bready  = 0;
logic        i_arvalid = 0;
logic        i_rready  = 0;
logic [2:0]  low       = 0;
wire  [2:0]  pin_n;
wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_output_disable, o_irq;
wire  [1:0]  o_bresp, o_rresp;
wire  [31:0] o_rdata;
logic [31:0] rdat, ctrl;
logic [1:0]  rsp;
logic [7:0]  a;
int          failures = 0;
int          n_tests  = 0;
odid_row_t   rows [12] = '{'{0,0,0,2,1,1}, '{1,1,4,40,1,1}, '{1,1,4,24,1,0}, '{2,2,2,48,1,1},
	'{0,3,1,256,1,1}, '{1,4,0,17,1,1}, '{1,4,0,15,1,0}, '{2,5,3,8,1,1}, '{0,6,4,20,1,1},
	'{0,6,4,12,1,0}, '{2,4,8,6,2,0}, '{1,7,1,40,1,0}};

always #12.5 i_ref_clk = ~i_ref_clk;

odid_src u_odid_src (.i_low(low), .o_pin_n(pin_n));
odid_top u_odid_top (.i_ref_clk, .i_srst, .i_ch0_request_pin_n(pin_n[0]),
	.i_ch4_request_pin_n(pin_n[1]), .i_ch8_request_pin_n(pin_n[2]), .i_awaddr, .i_awvalid,
	.o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
	.i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
	.o_output_disable, .o_irq);

////////////////////////////////////////////////////////////////////////////////
task chk(input [31:0] got, input [31:0] exp);
	n_tests++;
	if (got !== exp) begin
		failures++;
		$display("[FAIL] %0t got %h exp %h", $time, got, exp);
	end
endtask

task conclude;
	if (failures == 0 && n_tests > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask

task wr_reg(input [7:0] ad, input [31:0] d);
	logic ap, wp;
	ap = 1;
	wp = 1;
	@(posedge i_ref_clk);
	i_awaddr <= ad;
	i_wdata <= d;
	i_wstrb <= 4'hF;
	i_awvalid <= 1;
	i_wvalid <= 1;
	i_bready <= 1;
	while (ap || wp) begin
		@(posedge i_ref_clk);
		if (ap && o_awready) i_awvalid <= 0;
		if (wp && o_wready) i_wvalid <= 0;
		ap = ap && !o_awready;
		wp = wp && !o_wready;
	end
	while (o_bvalid !== 1'b1) @(posedge i_ref_clk);
	rsp = o_bresp;
	i_bready <= 0;
endtask

task rd_reg(input [7:0] ad);
	@(posedge i_ref_clk);
	i_araddr <= ad;
	i_arvalid <= 1;
	i_rready <= 1;
	do @(posedge i_ref_clk); while (o_arready !== 1'b1);
	i_arvalid <= 0;
	do @(posedge i_ref_clk); while (o_rvalid !== 1'b1);
	rdat = o_rdata;
	rsp = o_rresp;
	i_rready <= 0;
endtask

// each burst is followed by a three-cycle high gap so a sampler at clock/1 or /2 sees the line released
task pulse(input [1:0] ch, input int n, input int b);
	repeat (b) begin
		low[ch] <= 1;
		repeat (n) @(posedge i_ref_clk);
		low[ch] <= 0;
		repeat (3) @(posedge i_ref_clk);
	end
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
	#(25 * 30000);
	failures++;
	conclude();
end

initial begin
	repeat (6) @(posedge i_ref_clk);
	i_srst <= 0;
	wr_reg(`ODID_OFS_INT_MASK, 32'h7);
	foreach (rows[k]) begin
		ctrl = 32'h100 | {rows[k].cnt, rows[k].mode};
		a = `ODID_OFS_CH0 + {rows[k].ch, 2'b00};
		wr_reg(a, ctrl);
		pulse(rows[k].ch, rows[k].lo, rows[k].burst);
		repeat (6) @(posedge i_ref_clk);
		chk(o_output_disable, rows[k].exp);
		chk(o_irq, rows[k].exp);
		rd_reg(a);
		chk(rdat, ctrl | (rows[k].exp << `ODID_FLAG_BIT));
		wr_reg(a, ctrl);
		rd_reg(a);
		chk(rdat, ctrl);
		wr_reg(`ODID_OFS_INT_STAT, 32'h7);
	end
	// a clearing write without a prior read must be ignored
	wr_reg(`ODID_OFS_CH0, 32'h100);
	pulse(0, 2, 1);
	wr_reg(`ODID_OFS_CH0, 32'h100);
	rd_reg(`ODID_OFS_CH0);
	chk(rdat, 32'h1100);
	wr_reg(`ODID_OFS_CH0, 32'h100);
	rd_reg(`ODID_OFS_CH0);
	chk(rdat, 32'h100);
	// sampling mode: clear refused while the line is still low
	wr_reg(`ODID_OFS_CH4, 32'h114);
	low[1] <= 1;
	repeat (8) @(posedge i_ref_clk);
	rd_reg(`ODID_OFS_CH4);
	wr_reg(`ODID_OFS_CH4, 32'h114);
	rd_reg(`ODID_OFS_CH4);
	chk(rdat, 32'h1114);
	low[1] <= 0;
	repeat (4) @(posedge i_ref_clk);
	wr_reg(`ODID_OFS_CH4, 32'h114);
	rd_reg(`ODID_OFS_CH4);
	chk(rdat, 32'h114);
	// masked interrupt, disabled channel
	wr_reg(`ODID_OFS_INT_STAT, 32'h7);
	wr_reg(`ODID_OFS_INT_MASK, 32'h0);
	wr_reg(`ODID_OFS_CH8, 32'h0);
	pulse(2, 2, 1);
	repeat (4) @(posedge i_ref_clk);
	chk(o_irq, 0);
	chk(o_output_disable, 0);
	rd_reg(`ODID_OFS_INT_STAT);
	chk(rdat, 32'h4);
	wr_reg(`ODID_OFS_INT_MASK, 32'h4);
	repeat (2) @(posedge i_ref_clk);
	chk(o_irq, 1);
	wr_reg(`ODID_OFS_INT_STAT, 32'h4);
	repeat (2) @(posedge i_ref_clk);
	chk(o_irq, 0);
	// unmapped place
	rd_reg(8'h20);
	chk(rsp, `ODID_RESP_SLVERR);
	chk(rdat, 32'h0);
	wr_reg(8'h20, 32'hFFFF);
	chk(rsp, `ODID_RESP_SLVERR);
	// second reset clears the held flag and the mask
	i_srst <= 1;
	repeat (6) @(posedge i_ref_clk);
	i_srst <= 0;
	rd_reg(`ODID_OFS_CH8);
	chk(rdat, 32'h0);
	rd_reg(`ODID_OFS_INT_MASK);
	chk(rdat, 32'h0);
	conclude();
end
endmodule
